// ---- core/counter_qpwm.sv ----
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "counter_qpwm_regs.svh"

module counter_qpwm
   import counter_qpwm_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic count_trig,
   input wire logic start_trig,
   input wire logic reload_trig,
   input wire logic stop_trig,
   input wire logic switch_trig,
   output logic pwm_output,
   output logic terminal_count,
   output logic compare_capture_match,
   output logic wrap_high_event,
   output logic wrap_low_event
);

   localparam logic [CW-1:0] CNT_ZERO = '0;
   localparam logic [CW-1:0] CNT_MAX = '1;
   localparam logic [CW-1:0] CNT_ONE = CW'(1);

   // Edge detector shared by all event triggers
   function automatic logic edge_hit(input logic cur, input logic prev,
                                     input edge_mode_e mode);
      logic hit;
      hit = 1'b0;
      case (mode)
         edge_rising: hit = cur & ~prev;
         edge_falling: hit = ~cur & prev;
         edge_both: hit = cur ^ prev;
         edge_pass: hit = cur;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // Output line update for one configured action
   function automatic logic apply_action(input logic v, input action_e a);
      logic r;
      r = v;
      case (a)
         act_set: r = 1'b1;
         act_clear: r = 1'b0;
         act_invert: r = ~v;
         act_none: r = v;
         default: r = v;
      endcase
      return r;
   endfunction

   // Software visible state
   logic counter_on;
   counter_ctrl_s ctrl;
   logic [CW-1:0] period;
   logic [CW-1:0] period_buf;
   logic [CW-1:0] compare;
   logic [CW-1:0] compare_buf;
   logic [CW-1:0] capture;
   logic [CW-1:0] capture_buf;
   logic [2:0] trig_source;
   logic [5:0] trig_edge;
   logic [5:0] out_action;

   // Counter core state
   logic [CW-1:0] count;
   logic down;
   logic running;
   logic on_prev;
   logic switch_pending;
   logic cmd_reload;
   logic cmd_switch;

   // Bus data phase state
   logic wr_pend;
   logic [7:0] wr_addr;

   // Pin synchroniser: meta stage feeds only the sync stage
   logic [`TRIG_NUM-1:0] trig_meta;
   logic [`TRIG_NUM-1:0] trig_sync;
   logic [`TRIG_NUM-1:0] trig_prev;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trig_meta <= '0;
         trig_sync <= '0;
         trig_prev <= '0;
      end else begin
         trig_meta <= {switch_trig, stop_trig, reload_trig, start_trig, count_trig};
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end

   // Bus decode; every transfer completes with no wait state
   wire addr_ok = hsel & htrans[`HTRANS_ACTIVE_BIT] & hready;
   wire addr_wr = addr_ok & hwrite;
   wire addr_rd = addr_ok & ~hwrite;
   wire wr_global = wr_pend && wr_addr == `OFS_GLOBAL_CTRL;
   wire wr_ctrl = wr_pend && wr_addr == `OFS_COUNTER_CTRL;
   wire wr_compare = wr_pend && wr_addr == `OFS_COMPARE;
   wire wr_compare_buf = wr_pend && wr_addr == `OFS_COMPARE_BUF;
   wire wr_period = wr_pend && wr_addr == `OFS_PERIOD;
   wire wr_period_buf = wr_pend && wr_addr == `OFS_PERIOD_BUF;
   wire wr_source = wr_pend && wr_addr == `OFS_TRIG_SOURCE;
   wire wr_edge = wr_pend && wr_addr == `OFS_TRIG_EDGE;
   wire wr_action = wr_pend && wr_addr == `OFS_OUT_ACTION;

   // Mode decode
   wire quad_mode = ctrl.function_select == `FUNC_QUAD;
   wire pwm_mode = ctrl.function_select == `FUNC_PWM;
   wire run = counter_on & running;
   wire center = ctrl.count_direction_select == count_updown0;

   // Quadrature phases: A on count input, B on start input
   wire phase_a = trig_sync[`TRIG_COUNT];
   wire phase_b = trig_sync[`TRIG_START];
   wire a_rise = phase_a & ~trig_prev[`TRIG_COUNT];
   wire a_chg = phase_a ^ trig_prev[`TRIG_COUNT];
   wire b_chg = phase_b ^ trig_prev[`TRIG_START];

   // Step and direction per encoding; both phases moving at once is not allowed
   wire q_step = ctrl.encoding_select == single_rate_decode ? a_rise :
                 ctrl.encoding_select == double_rate_decode ? a_chg :
                 (a_chg | b_chg);
   wire q_up = ctrl.encoding_select == single_rate_decode ? ~phase_b :
               a_chg ? (phase_a ^ phase_b) : ~(phase_a ^ phase_b);

   // Trigger events
   wire index_ev = trig_source[`SRC_INDEX_BIT] & edge_hit(trig_sync[`TRIG_RELOAD],
      trig_prev[`TRIG_RELOAD], edge_mode_e'(trig_edge[`EDGE_INDEX_LSB +: 2]));
   wire stop_ev = trig_source[`SRC_STOP_BIT] & edge_hit(trig_sync[`TRIG_STOP],
      trig_prev[`TRIG_STOP], edge_mode_e'(trig_edge[`EDGE_STOP_LSB +: 2]));
   // A pass-through selection never raises a switch
   wire switch_hw = trig_source[`SRC_SWITCH_BIT] &
      edge_mode_e'(trig_edge[`EDGE_SWITCH_LSB +: 2]) != edge_pass &
      edge_hit(trig_sync[`TRIG_SWITCH], trig_prev[`TRIG_SWITCH],
               edge_mode_e'(trig_edge[`EDGE_SWITCH_LSB +: 2]));
   wire reload_ev = index_ev | cmd_reload;

   // Counter next state, events and capture
   logic [CW-1:0] next_count;
   logic [CW-1:0] stepped;
   logic [CW-1:0] cap_val;
   logic next_down;
   logic cap_hit;
   logic period_turn;
   events_s ev;

   always_comb begin
      next_count = count;
      stepped = count;
      cap_val = count;
      next_down = down;
      cap_hit = 1'b0;
      period_turn = 1'b0;
      ev = '0;
      if (run && quad_mode) begin
         if (reload_ev) begin
            ev.terminal_count = 1'b1;
            cap_hit = 1'b1;
            cap_val = count;
            next_count = down ? period : CNT_ZERO;
         end else if (q_step) begin
            stepped = q_up ? count + CNT_ONE : count - CNT_ONE;
            next_down = ~q_up;
            if (stepped == CNT_MAX || stepped == CNT_ZERO) begin
               ev.compare_capture_match = 1'b1;
               cap_hit = 1'b1;
               cap_val = stepped;
               next_count = period;
            end else begin
               next_count = stepped;
            end
         end
      end else if (run && pwm_mode) begin
         // Match checked every clock against the live count
         ev.compare_capture_match = count == compare;
         case (ctrl.count_direction_select)
            count_up: begin
               if (count >= period) begin
                  ev.terminal_count = 1'b1;
                  ev.wrap_high_event = 1'b1;
                  next_count = CNT_ZERO;
               end else begin
                  next_count = count + CNT_ONE;
               end
               next_down = 1'b0;
            end
            count_down: begin
               if (count == CNT_ZERO) begin
                  ev.terminal_count = 1'b1;
                  ev.wrap_low_event = 1'b1;
                  next_count = period;
               end else begin
                  next_count = count - CNT_ONE;
               end
               next_down = 1'b1;
            end
            default: begin
               // Up/down: turn at both ends, period cycle is twice as long
               if (!down && count >= period) begin
                  ev.wrap_high_event = 1'b1;
                  ev.terminal_count = ctrl.count_direction_select == count_updown1;
                  next_down = 1'b1;
                  next_count = count - CNT_ONE;
               end else if (down && count == CNT_ZERO) begin
                  ev.wrap_low_event = 1'b1;
                  ev.terminal_count = 1'b1;
                  period_turn = 1'b1;
                  next_down = 1'b0;
                  next_count = count + CNT_ONE;
               end else begin
                  next_count = down ? count - CNT_ONE : count + CNT_ONE;
               end
            end
         endcase
         // All modes except count_updown1 switch period at every terminal count
         if (ctrl.count_direction_select != count_updown1) begin
            period_turn = ev.terminal_count;
         end
      end
   end

   // Buffer swap takes effect only at a terminal count with a pending switch
   wire do_switch = pwm_mode & ev.terminal_count & switch_pending;
   wire swap_cmp = do_switch & ctrl.compare_swap_enable;
   wire swap_per = do_switch & ctrl.period_swap_enable & period_turn;

   // Count, direction and run state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count <= '0;
         down <= 1'b0;
         running <= 1'b0;
         on_prev <= 1'b0;
      end else begin
         on_prev <= counter_on;
         if (pwm_mode && counter_on && reload_ev) begin
            // Reload initialises the counter and starts it
            count <= ctrl.count_direction_select == count_down ? period : CNT_ZERO;
            down <= ctrl.count_direction_select == count_down;
         end else begin
            count <= next_count;
            down <= next_down;
         end
         if (!counter_on || stop_ev) begin
            running <= 1'b0;
         end else if ((counter_on && !on_prev && quad_mode) || (pwm_mode && reload_ev)) begin
            running <= 1'b1;
         end
      end
   end

   // Switch latch; a new switch in the clearing cycle is kept
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         switch_pending <= 1'b0;
      end else begin
         switch_pending <= switch_hw | cmd_switch | (switch_pending & ~do_switch);
      end
   end

   // Double-buffered capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         capture <= '0;
         capture_buf <= '0;
      end else if (cap_hit) begin
         capture_buf <= capture;
         capture <= cap_val;
      end
   end

   // PWM line; center alignment overrides the action table
   logic next_pwm;

   always_comb begin
      next_pwm = pwm_output;
      if (run && pwm_mode) begin
         if (center) begin
            if (ev.terminal_count) begin
               next_pwm = 1'b0;
            end else if (ev.compare_capture_match) begin
               next_pwm = ~pwm_output;
            end
         end else begin
            // Wrap events first, compare match last so it wins a tie
            if (ev.wrap_high_event) begin
               next_pwm = apply_action(next_pwm, action_e'(out_action[`ACT_WH_LSB +: 2]));
            end
            if (ev.wrap_low_event) begin
               next_pwm = apply_action(next_pwm, action_e'(out_action[`ACT_WL_LSB +: 2]));
            end
            if (ev.compare_capture_match) begin
               next_pwm = apply_action(next_pwm, action_e'(out_action[`ACT_CC_LSB +: 2]));
            end
         end
      end
   end

   // Registered event pulses and PWM line
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pwm_output <= 1'b0;
         terminal_count <= 1'b0;
         compare_capture_match <= 1'b0;
         wrap_high_event <= 1'b0;
         wrap_low_event <= 1'b0;
      end else begin
         pwm_output <= next_pwm;
         terminal_count <= ev.terminal_count;
         compare_capture_match <= ev.compare_capture_match;
         wrap_high_event <= ev.wrap_high_event;
         wrap_low_event <= ev.wrap_low_event;
      end
   end

   // Bus address phase capture and response
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_pend <= addr_wr;
         wr_addr <= haddr[7:0];
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Control registers; commands are one-cycle pulses
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         counter_on <= 1'b0;
         cmd_reload <= 1'b0;
         cmd_switch <= 1'b0;
         ctrl <= `RST_CTRL;
         trig_source <= `RST_SOURCE;
         trig_edge <= `RST_EDGE;
         out_action <= `RST_ACTION;
      end else begin
         cmd_reload <= wr_global & hwdata[`GLB_RELOAD_BIT];
         cmd_switch <= wr_global & hwdata[`GLB_SWITCH_BIT];
         if (wr_global) begin
            counter_on <= hwdata[`GLB_ON_BIT];
         end
         if (wr_ctrl) begin
            ctrl <= hwdata;
         end
         if (wr_source) begin
            trig_source <= hwdata[2:0];
         end
         if (wr_edge) begin
            trig_edge <= hwdata[5:0];
         end
         if (wr_action) begin
            out_action <= hwdata[5:0];
         end
      end
   end

   // Period and compare pairs; a software write beats a same-cycle swap
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period <= `RST_QUAD_PERIOD;
         period_buf <= `RST_QUAD_PERIOD;
         compare <= '0;
         compare_buf <= '0;
      end else begin
         if (wr_period) begin
            period <= hwdata[CW-1:0];
         end else if (swap_per) begin
            period <= period_buf;
         end
         if (wr_period_buf) begin
            period_buf <= hwdata[CW-1:0];
         end else if (swap_per) begin
            period_buf <= period;
         end
         if (wr_compare) begin
            compare <= hwdata[CW-1:0];
         end else if (swap_cmp) begin
            compare <= compare_buf;
         end
         if (wr_compare_buf) begin
            compare_buf <= hwdata[CW-1:0];
         end else if (swap_cmp) begin
            compare_buf <= compare;
         end
      end
   end

   // Read selection; unmapped offsets read as zero
   wire [7:0] ra = haddr[7:0];
   wire [31:0] state_word = {29'h0000_0000, switch_pending, running, down};
   wire [31:0] rd_value =
      ra == `OFS_GLOBAL_CTRL ? {31'h0000_0000, counter_on} :
      ra == `OFS_COUNTER_CTRL ? ctrl :
      ra == `OFS_COUNTER_STATE ? state_word :
      ra == `OFS_COUNT ? 32'(count) :
      ra == `OFS_COMPARE ? 32'(compare) :
      ra == `OFS_COMPARE_BUF ? 32'(compare_buf) :
      ra == `OFS_PERIOD ? 32'(period) :
      ra == `OFS_PERIOD_BUF ? 32'(period_buf) :
      ra == `OFS_TRIG_SOURCE ? {29'h0000_0000, trig_source} :
      ra == `OFS_TRIG_EDGE ? {26'h000_0000, trig_edge} :
      ra == `OFS_OUT_ACTION ? {26'h000_0000, out_action} :
      ra == `OFS_CAPTURE ? 32'(capture) :
      ra == `OFS_CAPTURE_BUF ? 32'(capture_buf) :
      32'h0000_0000;

   // Read data sampled in the address phase, presented in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (addr_rd) begin
         hrdata <= rd_value;
      end
   end

endmodule

// ---- core/counter_qpwm_pkg.sv ----
package counter_qpwm_pkg;

   typedef enum logic [1:0] {count_up, count_down, count_updown0, count_updown1} count_mode_e;
   typedef enum logic [1:0] {single_rate_decode, double_rate_decode, quad_rate_decode,
      decode_spare} encode_mode_e;
   typedef enum logic [1:0] {edge_rising, edge_falling, edge_both, edge_pass} edge_mode_e;
   typedef enum logic [1:0] {act_set, act_clear, act_invert, act_none} action_e;

   // Layout of counter_control_reg
   typedef struct packed {
      logic [4:0] spare_hi;
      logic [2:0] function_select;
      logic [1:0] spare_mid;
      encode_mode_e encoding_select;
      logic [1:0] spare_lo;
      count_mode_e count_direction_select;
      logic [13:0] spare_low;
      logic period_swap_enable;
      logic compare_swap_enable;
   } counter_ctrl_s;

   // Counter events of one cycle
   typedef struct packed {
      logic terminal_count;
      logic compare_capture_match;
      logic wrap_high_event;
      logic wrap_low_event;
   } events_s;

endpackage

// ---- core/counter_qpwm_regs.svh ----
`ifndef COUNTER_QPWM_REGS_SVH
`define COUNTER_QPWM_REGS_SVH

// Register byte offsets, decoded on haddr[7:0]
`define OFS_GLOBAL_CTRL 8'h00
`define OFS_COUNTER_CTRL 8'h04
`define OFS_COUNTER_STATE 8'h08
`define OFS_COUNT 8'h0c
`define OFS_COMPARE 8'h10
`define OFS_COMPARE_BUF 8'h14
`define OFS_PERIOD 8'h18
`define OFS_PERIOD_BUF 8'h1c
`define OFS_TRIG_SOURCE 8'h20
`define OFS_TRIG_EDGE 8'h24
`define OFS_OUT_ACTION 8'h28
`define OFS_CAPTURE 8'h2c
`define OFS_CAPTURE_BUF 8'h30

// Global control bits: enable level plus two self-clearing commands
`define GLB_ON_BIT 0
`define GLB_RELOAD_BIT 1
`define GLB_SWITCH_BIT 2

// Counter state register layout
`define ST_DOWN_BIT 0
`define ST_RUN_BIT 1
`define ST_PEND_BIT 2

// Function select codes
`define FUNC_QUAD 3'h3
`define FUNC_PWM 3'h4

// Trigger input indices in the synchroniser vector
`define TRIG_COUNT 0
`define TRIG_START 1
`define TRIG_RELOAD 2
`define TRIG_STOP 3
`define TRIG_SWITCH 4
`define TRIG_NUM 5

// Trigger source enables and edge fields
`define SRC_INDEX_BIT 0
`define SRC_STOP_BIT 1
`define SRC_SWITCH_BIT 2
`define EDGE_INDEX_LSB 0
`define EDGE_STOP_LSB 2
`define EDGE_SWITCH_LSB 4

// Output action fields
`define ACT_CC_LSB 0
`define ACT_WH_LSB 2
`define ACT_WL_LSB 4

// Reset values
`define RST_CTRL 32'h0000_0000
`define RST_EDGE 6'h00
`define RST_ACTION 6'h3f
`define RST_SOURCE 3'h0
`define RST_QUAD_PERIOD 16'h8000

// AHB transfer type bit that marks an active transfer
`define HTRANS_ACTIVE_BIT 1

`endif

// ---- verif/counter_qpwm_props.sv ----
`timescale 1ns/1ps
module counter_qpwm_props
   import counter_qpwm_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic pwm_output,
   input wire logic terminal_count,
   input wire logic compare_capture_match,
   input wire logic wrap_high_event,
   input wire logic wrap_low_event
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // The slave never inserts wait states and never answers with an error
   a_ready_high: assert property (hreadyout) else $error("hreadyout low");
   a_resp_okay: assert property (!hresp) else $error("hresp not OKAY");
   // Read data may only move after a read address phase is taken
   a_rdata_holds: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("hrdata moved without a read");
   // Events are single-cycle pulses; periods used here are never this short
   a_tc_pulse: assert property (terminal_count |=> !terminal_count)
      else $error("terminal_count longer than one cycle");
   a_high_pulse: assert property ($rose(wrap_high_event) |=> !wrap_high_event)
      else $error("wrap_high_event longer than one cycle");
   a_low_pulse: assert property (wrap_low_event |=> !wrap_low_event)
      else $error("wrap_low_event longer than one cycle");
   a_wrap_apart: assert property (!(wrap_high_event && wrap_low_event))
      else $error("both wrap events at once");
   // Output only rises on an event that carries an action
   a_rise_cause: assert property ($rose(pwm_output) |->
      (compare_capture_match || wrap_high_event || wrap_low_event))
      else $error("pwm_output rose without an event");

   c_tc: cover property (terminal_count);
   c_match: cover property (compare_capture_match);
   c_pwm_rise: cover property ($rose(pwm_output));
endmodule

bind counter_qpwm counter_qpwm_props i_props (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .pwm_output(pwm_output), .terminal_count(terminal_count),
   .compare_capture_match(compare_capture_match), .wrap_high_event(wrap_high_event),
   .wrap_low_event(wrap_low_event)
);

// ---- verif/counter_quadrature_pwm_modes_bench.sv ----
`timescale 1ns/1ps
`include "counter_qpwm_regs.svh"
module counter_quadrature_pwm_modes_bench
   import counter_qpwm_pkg::*;
;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b1;
   logic hwrite = 1'b0;
   logic stop_trig = 1'b0;
   logic switch_trig = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hrdata;
   logic hreadyout, hresp, pwm_output, terminal_count, compare_capture_match;
   logic wrap_high_event, wrap_low_event, phase_a, phase_b, index;
   int errors = 0;
   int checks_done = 0;
   int tc_n = 0;
   int cc_n = 0;
   int per, hi;
   wire logic [2:0] evs = {wrap_low_event, wrap_high_event, terminal_count};

   always #2 hclk = ~hclk;

   counter_qpwm i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .count_trig(phase_a),
      .start_trig(phase_b), .reload_trig(index), .stop_trig(stop_trig),
      .switch_trig(switch_trig), .pwm_output(pwm_output), .terminal_count(terminal_count),
      .compare_capture_match(compare_capture_match), .wrap_high_event(wrap_high_event),
      .wrap_low_event(wrap_low_event));

   quad_encoder i_enc (.clk(hclk), .phase_a(phase_a), .phase_b(phase_b), .index(index));

   // Pulse tallies, so scenarios need not poll every cycle
   always @(posedge hclk) begin
      tc_n <= tc_n + int'(terminal_count === 1'b1);
      cc_n <= cc_n + int'(compare_capture_match === 1'b1);
   end

   task automatic end_of_test();
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      checks_done++;
      if (v !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", s, e, v);
      end
   endtask

   // Bounded wait for hready; the slave has no wait states, so a long wait is a hang
   task automatic rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] r);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'b10;
      rdy();
      htrans <= 2'b00;
      hwdata <= d;
      rdy();
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rchk(input string s, input logic [7:0] a, input logic [31:0] e,
         input logic [31:0] m = 32'hffff_ffff);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(s, e & m, r & m);
   endtask

   // Cycles and high cycles of the output between two pulses of one event
   task automatic measure(input int s);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (evs[s] !== 1'b1 && n < 100);
      per = 0;
      hi = 0;
      do begin
         @(posedge hclk);
         per++;
         hi += int'(pwm_output === 1'b1);
      end while (evs[s] !== 1'b1 && per < 100);
      if (n >= 100 || per >= 100) begin
         errors++;
         end_of_test();
      end
   endtask

   task automatic t_regs();
      rchk("period reset", `OFS_PERIOD, 32'h8000);
      rchk("action reset", `OFS_OUT_ACTION, 32'h3f);
      wr(8'h40, 32'hffff_ffff);
      rchk("unmapped read", 8'h40, 32'h0);
      wr(`OFS_COUNTER_CTRL, 32'h0433_0003);
      rchk("ctrl readback", `OFS_COUNTER_CTRL, 32'h0433_0003);
   endtask

   task automatic quad_on(input logic [31:0] c);
      wr(`OFS_GLOBAL_CTRL, 32'h0);
      wr(`OFS_COUNTER_CTRL, c);
      wr(`OFS_TRIG_SOURCE, 32'h1);
      wr(`OFS_GLOBAL_CTRL, 32'h1);
   endtask

   // Index, up and down steps, underflow, then an index and an overflow
   task automatic t_quad();
      int n;
      wr(`OFS_PERIOD, 32'h8000);
      quad_on(32'h0300_0000);
      n = tc_n;
      i_enc.index_pulse();
      chk("index tc", n + 1, tc_n);
      rchk("count after index", `OFS_COUNT, 32'h0, 32'hffff);
      i_enc.step(1'b1, 8);
      rchk("count up", `OFS_COUNT, 32'h2, 32'hffff);
      rchk("direction up", `OFS_COUNTER_STATE, 32'h0, 32'h1);
      n = cc_n;
      i_enc.step(1'b0, 8);
      chk("underflow match", n + 1, cc_n);
      rchk("underflow capture", `OFS_CAPTURE, 32'h0, 32'hffff);
      rchk("underflow reload", `OFS_COUNT, 32'h8000, 32'hffff);
      rchk("direction down", `OFS_COUNTER_STATE, 32'h1, 32'h1);
      wr(`OFS_PERIOD, 32'hfffe);
      quad_on(32'h0300_0000);
      i_enc.index_pulse();
      rchk("index down load", `OFS_COUNT, 32'hfffe, 32'hffff);
      rchk("index capture", `OFS_CAPTURE, 32'h8000, 32'hffff);
      rchk("index capture buffer", `OFS_CAPTURE_BUF, 32'h0, 32'hffff);
      i_enc.step(1'b1, 4);
      rchk("overflow capture", `OFS_CAPTURE, 32'hffff, 32'hffff);
      rchk("overflow capture buffer", `OFS_CAPTURE_BUF, 32'h8000, 32'hffff);
      rchk("overflow reload", `OFS_COUNT, 32'hfffe, 32'hffff);
   endtask

   // One encoder cycle per encoding; code 3 behaves as the fastest rate
   task automatic t_rates();
      int per_cycle[4] = '{1, 2, 4, 4};
      for (int e = 0; e < 4; e++) begin
         quad_on(32'h0300_0000 | (e << 20));
         i_enc.index_pulse();
         i_enc.step(1'b1, 4);
         rchk("rate count", `OFS_COUNT, per_cycle[e], 32'hffff);
      end
   endtask

   task automatic pwm_on(input logic [31:0] c, input logic [31:0] p, input logic [31:0] a);
      wr(`OFS_GLOBAL_CTRL, 32'h0);
      wr(`OFS_COUNTER_CTRL, c);
      wr(`OFS_PERIOD, p);
      wr(`OFS_COMPARE, 32'h3);
      wr(`OFS_OUT_ACTION, a);
      wr(`OFS_GLOBAL_CTRL, 32'h3);
   endtask

   // Period 9, compare 3 in each alignment
   task automatic t_shapes();
      pwm_on(32'h0400_0000, 32'h9, 32'h31);
      measure(1);
      chk("left period", 10, per);
      chk("left high", 4, hi);
      pwm_on(32'h0401_0000, 32'h9, 32'h1c);
      measure(2);
      chk("right period", 10, per);
      chk("right high", 3, hi);
      pwm_on(32'h0402_0000, 32'h9, 32'h3f);
      measure(0);
      chk("center period", 18, per);
      chk("center high", 12, hi);
      pwm_on(32'h0403_0000, 32'h9, 32'h3f);
      measure(0);
      chk("asymmetric tc spacing", 9, per);
   endtask

   // Buffers written first, swap at the next terminal count; pass-through never swaps
   task automatic t_switch();
      pwm_on(32'h0402_0003, 32'h9, 32'h3f);
      wr(`OFS_PERIOD_BUF, 32'h5);
      wr(`OFS_COMPARE_BUF, 32'h1);
      measure(0);
      wr(`OFS_GLOBAL_CTRL, 32'h5);
      @(posedge hclk); // Latch sets one cycle after the command pulse
      rchk("switch pending", `OFS_COUNTER_STATE, 32'h4, 32'h4);
      measure(0);
      chk("swapped period", 10, per);
      chk("swapped high", 8, hi);
      rchk("swapped compare", `OFS_COMPARE, 32'h1, 32'hffff);
      rchk("old compare kept", `OFS_COMPARE_BUF, 32'h3, 32'hffff);
      rchk("switch cleared", `OFS_COUNTER_STATE, 32'h2, 32'h6);
      wr(`OFS_TRIG_SOURCE, 32'h4);
      wr(`OFS_TRIG_EDGE, 32'h30);
      switch_trig <= 1'b1;
      measure(0);
      measure(0);
      chk("pass-through no swap", 10, per);
      switch_trig <= 1'b0;
      wr(`OFS_TRIG_SOURCE, 32'h2);
      stop_trig <= 1'b1;
      repeat (4) @(posedge hclk);
      rchk("stopped", `OFS_COUNTER_STATE, 32'h0, 32'h2);
   endtask

   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_quad();
      t_rates();
      t_shapes();
      t_switch();
      end_of_test();
   end
endmodule

// ---- verif/quad_encoder.sv ----
`timescale 1ns/1ps
module quad_encoder
   import counter_qpwm_pkg::*;
(
   input wire logic clk,
   output logic phase_a = 1'b0,
   output logic phase_b = 1'b0,
   output logic index = 1'b0
);
   logic [1:0] pos = 2'h0;

   // Gray position 00, 10, 11, 01 moves forward; each state is held 4 clocks
   task automatic step(input logic up, input int n);
      repeat (n) begin
         pos = up ? pos + 2'h1 : pos - 2'h1;
         phase_a <= (pos == 2'h1) || (pos == 2'h2);
         phase_b <= pos[1];
         repeat (4) @(posedge clk);
      end
      repeat (8) @(posedge clk);
   endtask

   // Index pulse long enough to pass the input synchroniser
   task automatic index_pulse();
      index <= 1'b1;
      repeat (4) @(posedge clk);
      index <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule
